// ==== src/fsa_datapath.v ====
// Shift and add datapath for 40-bit complement fractions
`timescale 1ns/1ps
`include "fsa_map.vh"

// Notes on behaviour
// - Operands are 40-bit complement words; all positions take part.
// - Binary point sits after the leftmost bit; words are fractions.
// - Leftmost bit 0 is non-negative, 1 negative; 1000..0 is minus one.
// - Left and right shifts of zero to forty places are supported.
// - Left shift moves the one-half bit into the sign bit, modulo 2.
// - Right shift copies the sign into every vacated top position.
// - Bits shifted out past the bottom are kept on a spill output.
// - Right shift truncates, with no rounding.
// - Addition is modulo 2; carry out of the sign bit is dropped.
// - Subtraction inverts every bit, adds one at the bottom, then adds.
module fsa_datapath #(
   parameter WORD_W = `FSA_WORD_W,
   parameter CNT_W = `FSA_CNT_W
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // Operation request
   input wire op_valid,
   input wire [`FSA_OP_W-1:0] op_code,
   input wire [WORD_W-1:0] op_a,
   input wire [WORD_W-1:0] op_b,
   input wire [CNT_W-1:0] shift_count,
   // Result
   output reg res_valid,
   output reg [WORD_W-1:0] res_word,
   output reg [WORD_W-1:0] res_spill,
   output reg res_negative,
   output reg res_carry,
   output reg res_bad_count
);

   // Operation decode; codes outside the table fall through to pass
   wire is_shl;
   wire is_shr;
   wire is_add;
   wire is_sub;
   wire is_neg;
   wire is_shift;
   wire is_arith;
   assign is_shl = (op_code == `FSA_OP_SHL);
   assign is_shr = (op_code == `FSA_OP_SHR);
   assign is_add = (op_code == `FSA_OP_ADD);
   assign is_sub = (op_code == `FSA_OP_SUB);
   assign is_neg = (op_code == `FSA_OP_NEG);
   assign is_shift = is_shl | is_shr;
   assign is_arith = is_add | is_sub | is_neg;

   // Counts beyond forty saturate to forty so a shift never wraps
   wire count_bad;
   wire [CNT_W-1:0] count_eff;
   assign count_bad = (shift_count > `FSA_MAX_SHIFT);
   assign count_eff = count_bad ? `FSA_MAX_SHIFT : shift_count;

   // Double-width shifters; the low half of the right shift is the spill
   wire [2*WORD_W-1:0] shl_full;
   wire signed [2*WORD_W-1:0] shr_src;
   wire [2*WORD_W-1:0] shr_full;
   assign shl_full = {{WORD_W{1'b0}}, op_a} << count_eff;
   assign shr_src = {op_a, {WORD_W{1'b0}}};
   assign shr_full = shr_src >>> count_eff;

   // One adder serves add, subtract and negate; inverting plus carry-in forms the complement
   reg [WORD_W-1:0] add_x;
   reg [WORD_W-1:0] add_y;
   reg add_cin;
   wire [WORD_W:0] add_sum;
   wire [WORD_W:0] add_carry;

   // Ripple carry chain; the carry out of the top bit is kept only as a flag
   assign add_carry[0] = add_cin;
   genvar gi;
   generate
      for (gi = 0; gi < WORD_W; gi = gi + 1) begin : g_add_bit
         assign add_sum[gi] = add_x[gi] ^ add_y[gi] ^ add_carry[gi];
         assign add_carry[gi+1] = (add_x[gi] & add_y[gi]) |
            (add_carry[gi] & (add_x[gi] ^ add_y[gi]));
      end
   endgenerate
   // Result is taken modulo 2: this carry never reaches the word
   assign add_sum[WORD_W] = add_carry[WORD_W];

   always @* begin
      add_x = op_a;
      add_y = op_b;
      add_cin = 1'b0;
      case (op_code)
         `FSA_OP_SUB: begin
            add_y = ~op_b;
            add_cin = 1'b1;
         end
         `FSA_OP_NEG: begin
            add_x = {WORD_W{1'b0}};
            add_y = ~op_a;
            add_cin = 1'b1;
         end
         default: begin
            add_cin = 1'b0;
         end
      endcase
   end

   reg [WORD_W-1:0] word_next;
   reg [WORD_W-1:0] spill_next;
   reg carry_next;

   always @* begin
      word_next = op_a;
      spill_next = {WORD_W{1'b0}};
      carry_next = 1'b0;
      case (op_code)
         `FSA_OP_SHL: begin
            word_next = shl_full[WORD_W-1:0];
         end
         `FSA_OP_SHR: begin
            word_next = shr_full[2*WORD_W-1:WORD_W];
            spill_next = shr_full[WORD_W-1:0];
         end
         `FSA_OP_ADD, `FSA_OP_SUB, `FSA_OP_NEG: begin
            word_next = add_sum[WORD_W-1:0];
            carry_next = add_sum[WORD_W];
         end
         default: begin
            word_next = op_a;
         end
      endcase
   end

   // Results register once per request; all outputs but res_valid hold until the next request
   // Strobe is a one-cycle pulse that follows each accepted request
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_valid <= 1'b0;
      end else begin
         res_valid <= op_valid;
      end
   end

   // Full 40-bit result word
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_word <= {WORD_W{1'b0}};
      end else if (op_valid) begin
         res_word <= word_next;
      end
   end

   // Bits lost off the bottom of a right shift, highest lost bit on top
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_spill <= {WORD_W{1'b0}};
      end else if (op_valid) begin
         res_spill <= spill_next;
      end
   end

   // Sign is the leftmost bit; zero counts as non-negative
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_negative <= 1'b0;
      end else if (op_valid) begin
         res_negative <= word_next[WORD_W-1];
      end
   end

   // Carry is only meaningful after add, subtract or negate
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_carry <= 1'b0;
      end else if (op_valid) begin
         res_carry <= carry_next & is_arith;
      end
   end

   // Flag a clamped count only when the request really was a shift
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         res_bad_count <= 1'b0;
      end else if (op_valid) begin
         res_bad_count <= count_bad & is_shift;
      end
   end

endmodule // fsa_datapath

// ==== src/fsa_map.vh ====
// Constants for the fractional shift and add datapath
`ifndef FSA_MAP_VH
`define FSA_MAP_VH
`define FSA_WORD_W 40
`define FSA_CNT_W 6
`define FSA_MAX_SHIFT 6'h28
`define FSA_SIGN_BIT 39
`define FSA_OP_W 3
`define FSA_OP_PASS 3'h0
`define FSA_OP_SHL 3'h1
`define FSA_OP_SHR 3'h2
`define FSA_OP_ADD 3'h3
`define FSA_OP_SUB 3'h4
`define FSA_OP_NEG 3'h5
`define FSA_LATENCY 1
`endif

// ==== test/fsa_datapath_tb_top.sv ====
// Testbench for the shift and add datapath
`timescale 1ns/1ps
module fsa_datapath_tb_top;
   logic ref_clk = 0, rst = 1, op_valid, res_valid, res_negative, res_carry, res_bad_count;
   logic [2:0] op_code;
   logic [5:0] shift_count;
   logic [39:0] op_a, op_b, res_word, res_spill;
   int total_checks, miscompares;
   wire [81:0] r = {res_bad_count, res_negative, res_word, res_spill};
   always #2 ref_clk = ~ref_clk;
   fsa_seq_model fsa_seq_model_i (.*);
   fsa_datapath fsa_datapath_i (.*);
   task chk(string s, logic [81:0] x, y);
      total_checks++;
      if (x !== y) begin
         miscompares++;
         $display("Error %s expected %h seen %h", s, y, x);
      end
   endtask
   task test_done;
      $display("checks %0d errors %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task run(logic [2:0] c, logic [39:0] a, b, logic [5:0] n, logic [81:0] y, string s);
      fsa_seq_model_i.issue(c, a, b, n);
      repeat (3) if (res_valid !== 1'b1) @(negedge ref_clk);
      if (res_valid !== 1'b1) begin
         miscompares++;
         test_done;
      end
      chk(s, r, y);
   endtask
   task t_shift;
      logic signed [79:0] e;
      // Counts of 0, 19 and 38 keep every left shift of the all-ones operand inside the legal range
      for (int n = 0; n < 39; n += 19) run(1, '1, 0, n, {2'h1, {40{1'b1}} << n, 40'h0}, "shl");
      for (int n = 0; n < 41; n += n ? 36 : 4) begin
         e = $signed({40'h95_0000_00f5, 40'h0}) >>> n;
         run(2, 40'h95_0000_00f5, 0, n, {2'h1, e}, "shr");
      end
      run(2, 40'h40_0000_0001, 0, 6'h3f, {2'h2, 40'h0, 40'h40_0000_0001}, "bad");
   endtask
   task t_arith;
      run(3, 40'h80_0000_0000, 40'h80_0000_0000, 0, 0, "add");
      chk("carry", res_carry, 1);
      run(4, 40'h2b, 40'h47, 0, {2'h1, 40'hff_ffff_ffe4, 40'h0}, "sub");
      chk("carry", res_carry, 0);
      run(0, 40'h12_3456_789a, 0, 0, {2'h0, 40'h12_3456_789a, 40'h0}, "pass");
      run(7, 40'h80_0000_0000, 0, 6'h3f, {2'h1, 40'h80_0000_0000, 40'h0}, "other");
      run(5, 40'h80_0000_0000, 0, 0, {2'h1, 40'h80_0000_0000, 40'h0}, "neg");
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      rst = 0;
      chk("rst", r, 0);
      t_shift;
      @(negedge ref_clk);
      rst = 1;
      @(negedge ref_clk);
      chk("rst2", {r, res_valid, res_carry}, 0);
      rst = 0;
      t_arith;
      test_done;
   end
endmodule // fsa_datapath_tb_top

// ==== test/fsa_props.sv ====
// Checker for the shift and add datapath
`timescale 1ns/1ps
module fsa_props (input wire logic ref_clk, rst, op_valid, res_valid, res_negative, res_carry,
   res_bad_count, input wire logic [2:0] op_code, input wire logic [5:0] shift_count,
   input wire logic [39:0] op_a, op_b, res_word, res_spill);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_v; op_valid |=> res_valid; endproperty
   a_v: assert property (p_v) else $error("late");
   property p_p; !op_valid |=> !res_valid; endproperty
   a_p: assert property (p_p) else $error("pulse");
   property p_n; res_negative == res_word[39]; endproperty
   a_n: assert property (p_n) else $error("sign");
   property p_b; op_valid && op_code inside {1, 2} |=> res_bad_count == $past(shift_count) > 40;
   endproperty
   a_b: assert property (p_b) else $error("count");
   property p_l; op_valid && op_code == 1 |=> res_word == $past(op_a) << $past(shift_count);
   endproperty
   a_l: assert property (p_l) else $error("shl");
   // Counts above forty are clamped, so the spill check is held to legal counts
   property p_r; op_valid && op_code == 2 && shift_count < 41 |=> $signed({res_word, res_spill})
      == $signed({$past(op_a), 40'h0}) >>> $past(shift_count); endproperty
   a_r: assert property (p_r) else $error("shr");
   property p_s; op_valid && op_code == 3 |=> {res_carry, res_word} == $past(op_a) + $past(op_b);
   endproperty
   a_s: assert property (p_s) else $error("add");
   property p_d; op_valid && op_code == 4 |=> res_word == $past(op_a) + ~$past(op_b) + 1;
   endproperty
   a_d: assert property (p_d) else $error("sub");
endmodule // fsa_props
bind fsa_datapath fsa_props fsa_props_i (.*);

// ==== test/fsa_seq_model.sv ====
// Sequencer model issuing one-cycle requests
`timescale 1ns/1ps
module fsa_seq_model (input wire logic ref_clk, output logic op_valid,
   output logic [2:0] op_code, output logic [5:0] shift_count, output logic [39:0] op_a, op_b);
   initial {op_valid, op_code, shift_count, op_a, op_b} = 0;
   task issue(logic [2:0] c, logic [39:0] a, b, logic [5:0] n);
      @(negedge ref_clk);
      {op_valid, op_code, op_a, op_b, shift_count} = {1'b1, c, a, b, n};
      @(negedge ref_clk);
      op_valid = 0;
   endtask
endmodule // fsa_seq_model
